// ---- common/fps_pkg.sv ----
// Types shared by the fault-protection sequencer and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package fps_pkg;

  // ==========================================================
  // Sequencer states, Gray coded along the normal path
  // ==========================================================
  typedef enum logic [2:0] {
    FPS_ST_OFF   = 3'b000,  // Waiting for supply turn-on.
    FPS_ST_CHECK = 3'b001,  // Pin checks before switching.
    FPS_ST_RUN   = 3'b011,  // Switching allowed.
    FPS_ST_UVLO  = 3'b010,  // One supply lockout cycle.
    FPS_ST_RECOV = 3'b110   // Long recovery delay.
  } fps_state_type;

  // ==========================================================
  // Cause of the last fault
  // ==========================================================
  typedef enum logic [3:0] {
    FPS_C_NONE    = 4'h0,
    FPS_C_OPP     = 4'h1,
    FPS_C_SCP     = 4'h2,
    FPS_C_OCP     = 4'h3,
    FPS_C_CSSHORT = 4'h4,
    FPS_C_REFSD   = 4'h5,
    FPS_C_THERM   = 4'h6,
    FPS_C_P13OPEN = 4'h7,
    FPS_C_P13OV   = 4'h8,
    FPS_C_RDM     = 4'h9,
    FPS_C_RTZ     = 4'hA
  } fps_cause_type;

  // ==========================================================
  // Comparator outputs from the power stage, all asynchronous
  // ==========================================================
  typedef struct packed {
    logic vddOn;        // Supply at or above turn-on level.
    logic vddOff;       // Supply at or below turn-off level.
    logic refGood;      // Reference pin above power-good level.
    logic thermal;      // Junction at shutdown threshold.
    logic pplHit;       // Peak current at peak power limit.
    logic cstOpp;       // Peak current above over-power threshold.
    logic ocpHit;       // Current sense above over-current level.
    logic vsLow;        // Output sense pin below its low level.
    logic demagEnd;     // Demagnetization finished this cycle.
    logic p13Below14;   // Regulator pin below its open level.
    logic p13Over;      // Regulator pin above over-voltage level.
    logic rdmOpen;      // Demag programming pin current too small.
    logic rdmShort;     // Demag programming pin current too large.
    logic rtzOpen;      // Transition-zero pin current too small.
    logic rtzShort;     // Transition-zero pin current too large.
    logic setHigh;      // Select pin high.
    logic rdmHighRange; // Demag resistor above its range threshold.
  } fps_sense_type;

  // ==========================================================
  // Status reported to the rest of the controller
  // ==========================================================
  typedef struct packed {
    fps_state_type state;    // Current sequencer state.
    logic          uvloHold; // A lockout or recovery cycle is running.
    logic          recovery; // The long recovery delay is running.
    fps_cause_type cause;    // Cause of the last fault.
  } fps_status_type;

endpackage : fps_pkg

// ---- common/fps_regs.svh ----
// Timing constants of the fault-protection sequencer.
// Assumes a 125 MHz system clock; all cycle counts derive from it.
`ifndef FPS_REGS_SVH
`define FPS_REGS_SVH

// ==========================================================
// Clock and base tick
// ==========================================================
`define FPS_CLK_MHZ         125
`define FPS_TICK_NS         1000
`define FPS_TICK_CYC        ((`FPS_TICK_NS * `FPS_CLK_MHZ) / 1000)

// ==========================================================
// Fault times in their own units
// ==========================================================
`define FPS_OPP_TIME_MS     160
`define FPS_RECOV_TIME_MS   1500
`define FPS_CHECK_TIME_US   10
`define FPS_CSF_LONG_NS     2000
`define FPS_CSF_SHORT_NS    1000
`define FPS_LEB_TIME_NS     200

// ==========================================================
// Derived cycle counts (least times round up)
// ==========================================================
`define FPS_CHECK_CYC       ((`FPS_CHECK_TIME_US * `FPS_CLK_MHZ * 1000 + 999) / 1000)
`define FPS_CSF_LONG_CYC    ((`FPS_CSF_LONG_NS * `FPS_CLK_MHZ + 999) / 1000)
`define FPS_CSF_SHORT_CYC   ((`FPS_CSF_SHORT_NS * `FPS_CLK_MHZ + 999) / 1000)
`define FPS_LEB_CYC         ((`FPS_LEB_TIME_NS * `FPS_CLK_MHZ + 999) / 1000)

// ==========================================================
// Consecutive pulse counts
// ==========================================================
`define FPS_OCP_PULSES      3
`define FPS_OV_PULSES       3

`endif

// ---- sim/fps_fault_sequencer_properties.sv ----
// Port checker for the fault-protection sequencer.
// Assumes it is bound to the sequencer top and sees only its ports.
`timescale 1ns/10ps

// ==========================================================
// Checker
// ==========================================================
module fps_seq_properties import fps_pkg::*; #(
  parameter int unsigned OPP_TICKS   = 160000,  // Over-power time in ticks.
  parameter int unsigned RECOV_TICKS = 1500000, // Recovery time in ticks.
  parameter int unsigned TICK_CYC    = 125      // Clock cycles per tick.
) (
  input wire logic           clk,
  input wire logic           resetn,
  input wire fps_sense_type  sense,
  input wire logic           lowReq,
  input wire logic           highReq,
  input wire logic           lowSideGate_q,
  input wire logic           highSideGate_q,
  input wire logic           runOut_q,
  input wire fps_status_type status_q
);
  fps_state_type st;       // State field, named for brevity.
  logic [31:0]   recCnt_q; // Cycles spent in recovery so far.
  logic [31:0]   recCnt_d; // Next recovery count.
  assign st = status_q.state;

  // The count restarts outside recovery, so each delay is judged alone.
  always_comb begin
    recCnt_d = (st == FPS_ST_RECOV) ? recCnt_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk) begin
    recCnt_q <= resetn ? recCnt_d : 32'h0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Three samples in a row of a condition while running; this covers the
  // two synchroniser stages ahead of the decision.
  sequence s_run3(c);
    (st == FPS_ST_RUN && c) [*3];
  endsequence
  property p_idle_off;
    st != FPS_ST_RUN |-> !lowSideGate_q && !highSideGate_q && !runOut_q;
  endproperty
  property p_run_out;
    st == FPS_ST_RUN |-> runOut_q;
  endproperty
  property p_therm;
    s_run3(sense.thermal && sense.refGood && !sense.vddOff) |-> ##[1:3] st == FPS_ST_UVLO;
  endproperty
  property p_ref_sd;
    s_run3(!sense.refGood && !sense.vddOff) |-> ##[1:3] st == FPS_ST_UVLO;
  endproperty
  property p_off_short;
    s_run3(sense.vddOff && (sense.cstOpp || sense.vsLow)) |-> ##[1:3] st == FPS_ST_RECOV;
  endproperty
  property p_off_plain;
    s_run3(sense.vddOff && !sense.cstOpp && !sense.vsLow) |-> ##[1:3] st == FPS_ST_UVLO;
  endproperty
  property p_uvlo_hold;
    (st == FPS_ST_UVLO && !sense.vddOff) [*3] |=> st == FPS_ST_UVLO;
  endproperty
  property p_recov_len;
    st == FPS_ST_RECOV ##1 st != FPS_ST_RECOV |-> recCnt_q >= (RECOV_TICKS - 1) * TICK_CYC;
  endproperty

  a_idle_off: assert property (p_idle_off)
    else $error("gate or run output active outside run");
  a_run_out: assert property (p_run_out)
    else $error("run output low in run state");
  a_therm: assert property (p_therm)
    else $error("hot junction did not start lockout");
  a_ref_sd: assert property (p_ref_sd)
    else $error("low reference did not start lockout");
  a_off_short: assert property (p_off_short)
    else $error("short at turn-off did not start recovery");
  a_off_plain: assert property (p_off_plain)
    else $error("plain turn-off did not give lockout only");
  a_uvlo_hold: assert property (p_uvlo_hold)
    else $error("lockout left before turn-off level");
  a_recov_len: assert property (p_recov_len)
    else $error("recovery delay ended too soon");
endmodule : fps_seq_properties

bind fps_fault_sequencer fps_seq_properties #(
  .OPP_TICKS(OPP_TICKS), .RECOV_TICKS(RECOV_TICKS), .TICK_CYC(TICK_CYC)
) chk (
  .clk(clk), .resetn(resetn), .sense(sense), .lowReq(lowReq), .highReq(highReq),
  .lowSideGate_q(lowSideGate_q), .highSideGate_q(highSideGate_q), .runOut_q(runOut_q),
  .status_q(status_q)
);

// ---- sim/fps_fault_sequencer_tb.sv ----
// Self-checking bench for the fault-protection sequencer.
// Assumes the power-stage model and the bound checker are compiled first.
`timescale 1ns/10ps

// ==========================================================
// Bench top
// ==========================================================
module fps_fault_sequencer_tb import fps_pkg::*;;
  localparam int unsigned RECT  = 30;    // Recovery ticks, cut down.
  localparam int          LIMIT = 90000; // Cycle ceiling of the run.
  logic           clk;            // System clock.
  logic           resetn;         // Synchronous reset, active low.
  logic           lowReq;         // Low-side gate request.
  logic           highReq;        // High-side gate request.
  logic [7:0]     dly = 8'h14;    // Demag delay of the stage.
  fps_sense_type  base = '0;      // Levels being built by a task.
  fps_sense_type  lv;             // Levels applied to the stage.
  fps_sense_type  sense;          // Comparator outputs to the block.
  logic           lowGate;        // Low-side gate drive.
  logic           highGate;       // High-side gate drive.
  logic           runOut;         // Run output.
  fps_status_type status;         // Status word.
  int             mismatches = 0; // Failed comparisons.
  int             numChecks = 0;  // Comparisons made.
  int             cycles = 0;     // Cycles since start.

  fps_power_stage stage (.clk(clk), .resetn(resetn), .gate(lowGate), .levels(lv), .demagDly(dly),
    .sense(sense));
  fps_fault_sequencer #(.OPP_TICKS(20), .RECOV_TICKS(RECT), .TICK_CYC(125)) dut (
    .clk(clk), .resetn(resetn), .sense(sense), .lowReq(lowReq), .highReq(highReq),
    .lowSideGate_q(lowGate), .highSideGate_q(highGate), .runOut_q(runOut), .status_q(status));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // A hang is cut short here and counted as a mismatch.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      give_verdict();
    end
  end

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Always lets one edge pass, so callers never drive twice in a step.
  task wait_st(input fps_state_type s, input int lim);
    int i;
    i = 0;
    @(posedge clk);
    while (status.state !== s && i < lim) begin
      @(posedge clk);
      i++;
    end
    chk("state", status.state, s);
  endtask : wait_st

  // One supply cycle: down to the turn-off level, then up to turn-on.
  task restart();
    @(posedge clk);
    base.vddOff = 1'b1;
    base.vddOn  = 1'b0;
    lv <= base;
    wait_st(FPS_ST_OFF, 5000);
    base.vddOff = 1'b0;
    base.vddOn  = 1'b1;
    lv <= base;
  endtask : restart

  // Clean start into the run state; turn-on drops with the next change.
  task boot();
    base = '0;
    base.refGood = 1'b1;
    restart();
    tick(1200);
    chk("check wait", status.state, FPS_ST_CHECK);
    wait_st(FPS_ST_RUN, 100);
    base.vddOn = 1'b0;
  endtask : boot

  // One switching cycle; the stage model ends it with demag end.
  task pulse(input int on, input logic hit, input logic ov);
    @(posedge clk);
    base.ocpHit  = hit;
    base.p13Over = ov;
    lv <= base;
    lowReq <= 1'b1;
    tick(on);
    lowReq <= 1'b0;
    tick(int'(dly) + 8);
    base.ocpHit  = 1'b0;
    base.p13Over = 1'b0;
    lv <= base;
  endtask : pulse

  task t_pins();
    base.refGood = 1'b1;
    for (int i = 0; i < 5; i++) begin
      {base.rdmOpen, base.rdmShort, base.rtzOpen, base.rtzShort, base.p13Below14} = 5'h10 >> i;
      restart();
      wait_st(FPS_ST_UVLO, 1300);
      chk("pin", status.cause, i < 2 ? FPS_C_RDM : i < 4 ? FPS_C_RTZ : FPS_C_P13OPEN);
    end
  endtask : t_pins

  // Two hits, a clean cycle, then three hits; the last with a slow stage.
  task t_ocp();
    boot();
    for (int i = 0; i < 6; i++) begin
      dly <= (i == 5) ? 8'h3C : 8'h14;
      pulse(40, i != 2, 1'b0);
      if (i == 4) chk("ocp run", status.state, FPS_ST_RUN);
    end
    wait_st(FPS_ST_RECOV, 20);
    chk("ocp cause", status.cause, FPS_C_OCP);
    chk("rec flags", {status.uvloHold, status.recovery}, 2'h3);
    lowReq  <= 1'b1;
    highReq <= 1'b1;
    tick(4);
    chk("ocp gates", {lowGate, highGate, runOut}, 3'h0);
    lowReq  <= 1'b0;
    highReq <= 1'b0;
    base.vddOff = 1'b1;
    lv <= base;
    tick(3000);
    chk("early", status.state, FPS_ST_RECOV);
    wait_st(FPS_ST_OFF, 1000);
  endtask : t_ocp

  task t_therm();
    boot();
    base.thermal = 1'b1;
    lv <= base;
    wait_st(FPS_ST_UVLO, 10);
    chk("hot cause", status.cause, FPS_C_THERM);
    restart();
    wait_st(FPS_ST_UVLO, 20);
  endtask : t_therm

  // The reference is held low across two supply cycles, then released.
  task t_ref();
    boot();
    base.refGood = 1'b0;
    lv <= base;
    wait_st(FPS_ST_UVLO, 10);
    chk("ref cause", status.cause, FPS_C_REFSD);
    repeat (2) begin
      restart();
      lowReq <= 1'b1;
      wait_st(FPS_ST_UVLO, 20);
      chk("ref gate", lowGate, 1'b0);
      lowReq <= 1'b0;
    end
    boot();
  endtask : t_ref

  task t_turnoff();
    for (int i = 0; i < 3; i++) begin
      boot();
      base.cstOpp = (i == 0);
      base.vsLow  = (i == 1);
      base.vddOff = 1'b1;
      lv <= base;
      wait_st(i < 2 ? FPS_ST_RECOV : FPS_ST_UVLO, 10);
      chk("off cause", status.cause, i < 2 ? FPS_C_SCP : FPS_C_NONE);
    end
  endtask : t_turnoff

  task t_opp();
    boot();
    base.pplHit = 1'b1;
    lv <= base;
    tick(2300);
    chk("opp early", status.state, FPS_ST_RUN);
    wait_st(FPS_ST_RECOV, 300);
    chk("opp cause", status.cause, FPS_C_OPP);
  endtask : t_opp

  // First on-time against the long and the short limit.
  task t_cs();
    for (int i = 0; i < 3; i++) begin
      boot();
      base.setHigh = (i < 2);
      pulse(i == 0 ? 200 : i == 1 ? 300 : 150, 1'b0, 1'b0);
      chk("first on", status.state, i == 0 ? FPS_ST_RUN : FPS_ST_RECOV);
    end
  endtask : t_cs

  task t_p13();
    boot();
    highReq <= 1'b1;
    tick(3);
    chk("high gate", highGate, 1'b1);
    highReq <= 1'b0;
    for (int i = 0; i < 3; i++) pulse(40, 1'b0, 1'b1);
    wait_st(FPS_ST_UVLO, 10);
    chk("ov cause", status.cause, FPS_C_P13OV);
  endtask : t_p13

  task give_verdict();
    $display("Checks %0d, mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    resetn  = 1'b0;
    lowReq  = 1'b0;
    highReq = 1'b0;
    lv      = '0;
    tick(6);
    chk("reset", {status, lowGate, highGate, runOut}, 12'h000);
    resetn <= 1'b1;
    t_pins();
    t_ocp();
    t_therm();
    t_ref();
    t_turnoff();
    t_opp();
    t_cs();
    t_p13();
    give_verdict();
  end
endmodule : fps_fault_sequencer_tb

// ---- sim/fps_power_stage.sv ----
// Behavioural model of the flyback power stage and its sense network.
// Assumes the bench sets static comparator levels; demag end is made here.
`timescale 1ns/10ps

// ==========================================================
// Power stage model
// ==========================================================
module fps_power_stage import fps_pkg::*; (
  input  wire logic          clk,
  input  wire logic          resetn,
  input  wire logic          gate,     // Low-side gate drive from the block.
  input  wire fps_sense_type levels,   // Levels chosen by the bench.
  input  wire logic [7:0]    demagDly, // Cycles from turn-off to demag end.
  output fps_sense_type      sense     // Comparator outputs to the block.
);
  logic [7:0] offCnt_q; // Cycles since the gate went off.
  logic [7:0] offCnt_d; // Next value, saturating so idle stays demagnetised.

  // A slow stage is a longer demag delay; the count stops at its top.
  always_comb begin
    offCnt_d = gate ? 8'h00 : ((offCnt_q == 8'hFF) ? offCnt_q : offCnt_q + 8'h01);
  end
  always_ff @(posedge clk) begin
    offCnt_q <= resetn ? offCnt_d : 8'hFF;
  end

  // Demag ends only once the gate is off and the winding has emptied.
  always_comb begin
    sense          = levels;
    sense.demagEnd = !gate && (offCnt_q >= demagDly);
  end
endmodule : fps_power_stage

// ---- src/fps_fault_sequencer.sv ----
// Fault-protection sequencer of a flyback controller.
// Assumes asynchronous comparator inputs and gate requests from
// the control loop on the same clock.
`timescale 1ns/10ps
`include "fps_regs.svh"

module fps_fault_sequencer import fps_pkg::*; #(
  parameter int unsigned OPP_TICKS   = `FPS_OPP_TIME_MS * 1000,   // Over-power time in 1 us ticks.
  parameter int unsigned RECOV_TICKS = `FPS_RECOV_TIME_MS * 1000, // Recovery time in 1 us ticks.
  parameter int unsigned TICK_CYC    = `FPS_TICK_CYC              // Clock cycles per tick.
) (
  input  wire logic           clk,
  input  wire logic           resetn,
  input  wire fps_sense_type  sense,
  input  wire logic           lowReq,
  input  wire logic           highReq,
  output logic                lowSideGate_q,
  output logic                highSideGate_q,
  output logic                runOut_q,
  output fps_status_type      status_q
);

  // ==========================================================
  // Constants at the width of what they meet
  // ==========================================================
  localparam logic [20:0] OPP_LIM    = 21'(OPP_TICKS);
  localparam logic [20:0] RECOV_LIM  = 21'(RECOV_TICKS);
  localparam logic [6:0]  TICK_LIM   = 7'(TICK_CYC - 1);
  localparam logic [11:0] CHECK_LIM  = 12'(`FPS_CHECK_CYC);
  localparam logic [11:0] CSF_LONG   = 12'(`FPS_CSF_LONG_CYC);
  localparam logic [11:0] CSF_SHORT  = 12'(`FPS_CSF_SHORT_CYC);
  localparam logic [7:0]  LEB_LIM    = 8'(`FPS_LEB_CYC);

  // ==========================================================
  // Input synchroniser
  // ==========================================================
  fps_sense_type senseMeta_q; // First stage, read only by the second.
  fps_sense_type sn;          // Second stage, safe for logic.

  // Every comparator output is asynchronous to clk.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      senseMeta_q <= '0;
      sn          <= '0;
    end else begin
      senseMeta_q <= sense;
      sn          <= senseMeta_q;
    end
  end

  // ==========================================================
  // Microsecond tick divider
  // ==========================================================
  logic [6:0] tickCnt_q;  // Cycle count inside one tick.
  logic [6:0] tickCnt_d;
  logic       tick_q;     // One-cycle pulse every microsecond.
  logic       tick_d;

  // A slow enable keeps the long timers narrow.
  always_comb begin
    tick_d    = (tickCnt_q == TICK_LIM);
    tickCnt_d = tick_d ? 7'h00 : tickCnt_q + 7'h01;
  end

  // Registers only.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tickCnt_q <= 7'h00;
      tick_q    <= 1'b0;
    end else begin
      tickCnt_q <= tickCnt_d;
      tick_q    <= tick_d;
    end
  end

  // ==========================================================
  // Sequencer state
  // ==========================================================
  fps_state_type state_q, state_d;  // Sequencer state.
  fps_cause_type cause_q, cause_d;  // Last fault cause.
  logic [20:0]   usTmr_q, usTmr_d;  // Over-power or recovery ticks.
  logic [11:0]   shCnt_q, shCnt_d;  // Check time or first on-time.
  logic [7:0]    lebCnt_q, lebCnt_d; // Blanking count per cycle.
  logic          first_q, first_d;  // First gate pulse not yet done.
  logic          lowPrev_q;         // Low request one cycle ago.
  logic          demPrev_q;         // Demag end one cycle ago.
  logic          ocpSeen_q, ocpSeen_d; // Over-current seen this cycle.
  logic          ovSeen_q, ovSeen_d;   // Over-voltage seen this cycle.
  logic          lowGate_d, highGate_d, run_d;
  logic          inRun, cycleStart, cycleEnd, lebDone;
  logic          ocpTrip, ovTrip, cntClear;
  logic [11:0]   csfLim;

  // Cycle boundaries seen only while switching is allowed.
  assign inRun      = (state_q == FPS_ST_RUN);
  assign cycleStart = inRun && lowReq && !lowPrev_q;
  assign cycleEnd   = inRun && sn.demagEnd && !demPrev_q;
  assign lebDone    = (lebCnt_q == LEB_LIM);
  assign cntClear   = !inRun;

  // Select pin high, or a large demag resistor, gives the long limit.
  assign csfLim = (sn.setHigh || sn.rdmHighRange) ? CSF_LONG : CSF_SHORT;

  // ==========================================================
  // Consecutive-cycle fault counters
  // ==========================================================
  fps_pulse_counter #(
    .LIMIT (`FPS_OCP_PULSES),
    .W     (2)
  ) u_ocp_count (
    .clk    (clk),
    .resetn (resetn),
    .clear  (cntClear),
    .step   (cycleEnd),
    .hit    (ocpSeen_q),
    .trip_q (ocpTrip)
  );

  fps_pulse_counter #(
    .LIMIT (`FPS_OV_PULSES),
    .W     (2)
  ) u_ov_count (
    .clk    (clk),
    .resetn (resetn),
    .clear  (cntClear),
    .step   (cycleEnd),
    .hit    (ovSeen_q),
    .trip_q (ovTrip)
  );

  // ==========================================================
  // Next-state logic
  // ==========================================================
  // Faults are ranked: supply loss decides first, since the
  // turn-off moment is when a short must be told apart.
  always_comb begin
    state_d   = state_q;
    cause_d   = cause_q;
    usTmr_d   = usTmr_q;
    shCnt_d   = shCnt_q;
    first_d   = first_q;
    lebCnt_d  = cycleStart ? 8'h00 : (lebDone ? lebCnt_q : lebCnt_q + 8'h01);
    ocpSeen_d = ocpSeen_q;
    ovSeen_d  = ovSeen_q;
    // A new cycle forgets what the last one saw.
    if (cycleStart) begin
      ocpSeen_d = 1'b0;
      ovSeen_d  = 1'b0;
    end else if (inRun) begin
      // Over-current only counts inside the sense window.
      if (lebDone && !sn.demagEnd && sn.ocpHit) begin
        ocpSeen_d = 1'b1;
      end
      if (sn.p13Over) begin
        ovSeen_d = 1'b1;
      end
    end
    unique case (state_q)
      FPS_ST_OFF: begin
        usTmr_d = 21'h000000;
        shCnt_d = 12'h000;
        if (sn.vddOn) begin
          state_d = FPS_ST_CHECK;
        end
      end
      FPS_ST_CHECK: begin
        first_d = 1'b1;
        shCnt_d = shCnt_q + 12'h001;
        // Pin checks run before any gate pulse.
        if (!sn.refGood) begin
          state_d = FPS_ST_UVLO;
          cause_d = FPS_C_REFSD;
        end else if (sn.thermal) begin
          state_d = FPS_ST_UVLO;
          cause_d = FPS_C_THERM;
        end else if (sn.rdmOpen || sn.rdmShort) begin
          state_d = FPS_ST_UVLO;
          cause_d = FPS_C_RDM;
        end else if (sn.rtzOpen || sn.rtzShort) begin
          state_d = FPS_ST_UVLO;
          cause_d = FPS_C_RTZ;
        end else if (shCnt_q == CHECK_LIM) begin
          shCnt_d = 12'h000;
          if (sn.p13Below14) begin
            state_d = FPS_ST_UVLO;
            cause_d = FPS_C_P13OPEN;
          end else begin
            state_d = FPS_ST_RUN;
            usTmr_d = 21'h000000;
          end
        end
      end
      FPS_ST_RUN: begin
        // The over-power timer runs only while the peak is high.
        if (!(sn.cstOpp || sn.pplHit)) begin
          usTmr_d = 21'h000000;
        end else if (tick_q) begin
          usTmr_d = usTmr_q + 21'h000001;
        end
        // First pulse on-time is measured while the gate is on.
        if (first_q && lowSideGate_q) begin
          shCnt_d = shCnt_q + 12'h001;
          if (!lowReq) begin
            first_d = 1'b0;
          end
        end
        if (sn.vddOff) begin
          if (sn.cstOpp || sn.vsLow) begin
            state_d = FPS_ST_RECOV;
            cause_d = FPS_C_SCP;
          end else begin
            state_d = FPS_ST_UVLO;
            cause_d = FPS_C_NONE;
          end
        end else if (!sn.refGood) begin
          state_d = FPS_ST_UVLO;
          cause_d = FPS_C_REFSD;
        end else if (sn.thermal) begin
          state_d = FPS_ST_UVLO;
          cause_d = FPS_C_THERM;
        end else if (first_q && shCnt_q > csfLim) begin
          state_d = FPS_ST_RECOV;
          cause_d = FPS_C_CSSHORT;
        end else if (ocpTrip) begin
          state_d = FPS_ST_RECOV;
          cause_d = FPS_C_OCP;
        end else if (usTmr_q == OPP_LIM) begin
          state_d = FPS_ST_RECOV;
          cause_d = FPS_C_OPP;
        end else if (ovTrip) begin
          state_d = FPS_ST_UVLO;
          cause_d = FPS_C_P13OV;
        end
        if (state_d != FPS_ST_RUN) begin
          usTmr_d = 21'h000000;
        end
      end
      FPS_ST_UVLO: begin
        // One supply lockout cycle, nothing switches.
        if (sn.vddOff) begin
          state_d = FPS_ST_OFF;
        end
      end
      FPS_ST_RECOV: begin
        // The delay completes first; restart waits for turn-off.
        if (usTmr_q != RECOV_LIM) begin
          if (tick_q) begin
            usTmr_d = usTmr_q + 21'h000001;
          end
        end else if (sn.vddOff) begin
          state_d = FPS_ST_OFF;
        end
      end
      default: begin
        state_d = FPS_ST_OFF;
      end
    endcase
    // Gates only follow requests in the run state.
    lowGate_d  = (state_d == FPS_ST_RUN) && lowReq;
    highGate_d = (state_d == FPS_ST_RUN) && highReq && !lowReq;
    run_d      = (state_d == FPS_ST_RUN);
  end

  // Registers only.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q        <= FPS_ST_OFF;
      cause_q        <= FPS_C_NONE;
      usTmr_q        <= 21'h000000;
      shCnt_q        <= 12'h000;
      lebCnt_q       <= 8'h00;
      first_q        <= 1'b0;
      lowPrev_q      <= 1'b0;
      demPrev_q      <= 1'b0;
      ocpSeen_q      <= 1'b0;
      ovSeen_q       <= 1'b0;
      lowSideGate_q  <= 1'b0;
      highSideGate_q <= 1'b0;
      runOut_q       <= 1'b0;
      status_q       <= '0;
    end else begin
      state_q        <= state_d;
      cause_q        <= cause_d;
      usTmr_q        <= usTmr_d;
      shCnt_q        <= shCnt_d;
      lebCnt_q       <= lebCnt_d;
      first_q        <= first_d;
      lowPrev_q      <= lowReq;
      demPrev_q      <= sn.demagEnd;
      ocpSeen_q      <= ocpSeen_d;
      ovSeen_q       <= ovSeen_d;
      lowSideGate_q  <= lowGate_d;
      highSideGate_q <= highGate_d;
      runOut_q       <= run_d;
      status_q.state    <= state_d;
      status_q.uvloHold <= (state_d == FPS_ST_UVLO) || (state_d == FPS_ST_RECOV);
      status_q.recovery <= (state_d == FPS_ST_RECOV);
      status_q.cause    <= cause_d;
    end
  end

endmodule : fps_fault_sequencer

// ---- src/fps_pulse_counter.sv ----
// Counter of consecutive switching cycles that exceed a limit.
// Assumes step is a one-cycle pulse at the end of each cycle.
`timescale 1ns/10ps

// ==========================================================
// Consecutive-cycle counter with registered trip output
// ==========================================================
module fps_pulse_counter #(
  parameter int unsigned LIMIT = 3,  // Cycles in a row that trip.
  parameter int unsigned W     = 2   // Counter width.
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic clear,   // Restart from zero.
  input  wire logic step,    // End of one switching cycle.
  input  wire logic hit,     // The limit was exceeded in it.
  output logic      trip_q   // Limit exceeded LIMIT cycles in a row.
);

  logic [W-1:0] count_q;  // Cycles in a row so far.
  logic [W-1:0] count_d;
  logic         trip_d;

  // Next count: a clean cycle breaks the run and zeroes it.
  always_comb begin
    count_d = count_q;
    trip_d  = 1'b0;
    if (clear) begin
      count_d = '0;
    end else if (step) begin
      if (!hit) begin
        count_d = '0;
      end else if (count_q == W'(LIMIT - 1)) begin
        count_d = '0;
        trip_d  = 1'b1;
      end else begin
        count_d = count_q + W'(1);
      end
    end
  end

  // Registers only.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      count_q <= '0;
      trip_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      trip_q  <= trip_d;
    end
  end

endmodule : fps_pulse_counter
